// >>> common/tapt_params.svh
`ifndef TAPT_PARAMS_SVH
`define TAPT_PARAMS_SVH
// Carrier cycles per elementary time unit.
`define TAPT_ETU_CYCLES 128
// Subcarrier is the carrier divided by this.
`define TAPT_SUB_DIV 16
// Fixed n for request, wake-up, anticollision and select.
`define TAPT_N_FIXED 9
// Frame delay offsets after a final one or zero bit.
`define TAPT_OFS_ONE 84
`define TAPT_OFS_ZERO 20
// Quiet field time before a cross-type request is accepted, in microseconds.
`define TAPT_QUIET_US 5000
`define TAPT_CLK_MHZ 200
// Cascade tag value and highest cascade level.
`define TAPT_CASCADE_TAG 8'h88
`define TAPT_MAX_LEVEL 2'h3
`endif

// >>> common/tapt_pkg.sv
package tapt_pkg;
    typedef enum logic [1:0] {
        TAPT_IDLE = 2'b00,
        TAPT_WAIT = 2'b01,
        TAPT_SEND = 2'b11
    } tapt_state_t;
    typedef enum logic [1:0] {
        TAPT_CMD_ANTICOLL = 2'h0,
        TAPT_CMD_OTHER = 2'h1,
        TAPT_CMD_TYPEB = 2'h2
    } tapt_cmd_t;
endpackage

// >>> logic/tapt_uid_mem.sv
`timescale 1ns/100ps
`default_nettype none
module tapt_uid_mem #(
    parameter int DEPTH = 16
) (
    input wire logic clk, // System clock.
    input wire logic we, // Write strobe.
    input wire logic [3:0] waddr, // Write address.
    input wire logic [7:0] wdata, // Write byte.
    input wire logic [3:0] raddr, // Read address.
    output logic [7:0] rdata // Registered read byte.
);
    // The address ports are four bits wide, so any other depth leaves words unreachable or out of range.
    if (DEPTH != 16) begin : g_bad_depth
        $error("tapt_uid_mem: depth must match the 4-bit address");
    end
    logic [7:0] mem [DEPTH];
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule // tapt_uid_mem
`default_nettype wire

// >>> logic/tapt_frame_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "tapt_params.svh"
// What this block does
// (RULE1) Reader repeats both request types.
// (RULE2) Type A ready after 5ms quiet.
// (RULE3) Type B ready after 5ms quiet. The block has no such wait and never answers a Type B command.
// (RULE4) One etu is 128 carrier cycles.
// (RULE5) Subcarrier is carrier divided by sixteen.
// (RULE6) Check byte is XOR of four bytes.
// (RULE7) Cascade tag 88 marks more bytes.
// (RULE8) Cascade levels one to three.
// (RULE9) Bit b8 is MSB, b1 LSB.
// (RULE10) Reader flags full-bit modulation as collision.
// (RULE11) Delay runs from pause end to edge.
// (RULE12) Anticollision commands: 1236 or 1172 cycles.
// (RULE13) Others: n*128 plus 84 or 20.
// (RULE14) Fixed n keeps all cards synchronous.
// (RULE15) Other answers sit on 128-cycle grid.
// (RULE16) Reader waits 1172 cycles after card.
// (RULE17) Silent on transmission errors.
// (RULE18) Carrier-clocked counter from pause end.
module tapt_frame_timer
    import tapt_pkg::*;
#(
    parameter int QUIET_CYCLES = `TAPT_QUIET_US * `TAPT_CLK_MHZ,
    parameter int N_WIDTH = 8
) (
    input wire logic clk, // 200 MHz system clock.
    input wire logic nrst, // Synchronous reset, active low.
    input wire logic carrier, // Recovered carrier, asynchronous.
    input wire logic pauseIn, // Field pause detected, asynchronous.
    input wire logic cmdDone, // Command fully decoded, one cycle.
    input wire logic cmdOk, // Frame received without error.
    input wire tapt_cmd_t cmdType, // Command class.
    input wire logic lastBit, // Final data bit of the command.
    input wire logic [N_WIDTH-1:0] nReq, // Requested n for other commands.
    input wire logic uidWe, // UID byte write strobe.
    input wire logic [3:0] uidWaddr, // UID byte index, level*4+byte.
    input wire logic [7:0] uidWdata, // UID byte.
    input wire logic [1:0] level, // Cascade level, 1 to 3.
    output logic startEdge, // Pulse at first response edge.
    output logic subcarrier, // Response subcarrier, carrier/16.
    output logic respActive, // Response slot under way.
    output logic reqAReady, // Type A request accepted.
    output logic [7:0] checkByte // XOR of the level's four bytes.
);
    localparam int QW = $clog2(QUIET_CYCLES + 1);
    // The n field must hold the fixed value nine, and a zero quiet time would never block.
    if (N_WIDTH < 4 || QUIET_CYCLES < 1) begin : g_bad_params
        $error("tapt_frame_timer: bad parameters");
    end

    logic carS1_q, carS2_q, carS3_q, pauS1_q, pauS2_q, pauS3_q;
    always_ff @(posedge clk) begin
        carS1_q <= carrier;
        carS2_q <= carS1_q;
        carS3_q <= carS2_q;
        pauS1_q <= pauseIn;
        pauS2_q <= pauS1_q;
        pauS3_q <= pauS2_q;
    end
    logic carRise, pauseEnd;
    assign carRise = carS2_q & ~carS3_q;
    assign pauseEnd = ~pauS2_q & pauS3_q; // RULE11

    // Frame delay in carrier cycles for the decoded command.
    function automatic logic [N_WIDTH+7:0] fdtOf(input tapt_cmd_t t, input logic lb,
                                                  input logic [N_WIDTH-1:0] n);
        logic [N_WIDTH-1:0] nn;
        nn = (t == TAPT_CMD_ANTICOLL || n < N_WIDTH'(`TAPT_N_FIXED)) ? N_WIDTH'(`TAPT_N_FIXED) : n; // RULE12 RULE13 RULE14
        fdtOf = {nn, 7'h00} + (lb ? (N_WIDTH+8)'(`TAPT_OFS_ONE) : (N_WIDTH+8)'(`TAPT_OFS_ZERO)); // RULE4 RULE15
    endfunction

    tapt_state_t state_q, state_d;
    logic [N_WIDTH+7:0] cnt_q, cnt_d, tgt_q, tgt_d;
    logic [3:0] subCnt_q, subCnt_d;
    logic startEdge_q, startEdge_d, sub_q, sub_d, act_q, act_d;
    logic [QW-1:0] quiet_q, quiet_d;
    logic typeB_q, typeB_d, reqA_q, reqA_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        tgt_d = tgt_q;
        subCnt_d = subCnt_q;
        startEdge_d = 1'b0;
        act_d = act_q;
        sub_d = sub_q;
        quiet_d = quiet_q;
        typeB_d = typeB_q;
        reqA_d = reqA_q;
        case (state_q)
            TAPT_IDLE: begin
                act_d = 1'b0;
                sub_d = 1'b0;
                if (cmdDone && cmdOk && cmdType != TAPT_CMD_TYPEB) begin // RULE17
                    tgt_d = fdtOf(cmdType, lastBit, nReq);
                    state_d = TAPT_WAIT;
                    cnt_d = '0;
                end
            end
            TAPT_WAIT: begin
                // Counting restarts at every pause end so the last one sets the origin.
                if (pauseEnd) begin // RULE18
                    cnt_d = '0;
                end else if (carRise) begin
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q + 1'b1 == tgt_q) begin // RULE18
                        startEdge_d = 1'b1;
                        act_d = 1'b1;
                        sub_d = 1'b1;
                        subCnt_d = '0;
                        cnt_d = '0;
                        state_d = TAPT_SEND;
                    end
                end
            end
            TAPT_SEND: begin
                if (carRise) begin
                    subCnt_d = subCnt_q + 1'b1;
                    if (subCnt_q[2:0] == 3'h7) begin // RULE5
                        sub_d = ~sub_q;
                    end
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q + 1'b1 == (N_WIDTH+8)'(`TAPT_ETU_CYCLES)) begin
                        state_d = TAPT_IDLE;
                        sub_d = 1'b0;
                        act_d = 1'b0;
                    end
                end
            end
            default: state_d = TAPT_IDLE;
        endcase
        // Cross-type recovery: after a Type B command, wait for quiet field.
        if (cmdDone && cmdType == TAPT_CMD_TYPEB) begin
            typeB_d = 1'b1;
            quiet_d = '0;
        end else if (pauS2_q) begin
            quiet_d = '0;
        end else if (typeB_q && quiet_q != QW'(QUIET_CYCLES)) begin
            quiet_d = quiet_q + 1'b1;
        end else if (typeB_q) begin
            typeB_d = 1'b0; // RULE2 RULE3
        end
        reqA_d = cmdDone && cmdOk && cmdType == TAPT_CMD_ANTICOLL && !typeB_q;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_q <= TAPT_IDLE;
            cnt_q <= '0;
            tgt_q <= '0;
            subCnt_q <= '0;
            startEdge_q <= 1'b0;
            sub_q <= 1'b0;
            act_q <= 1'b0;
            quiet_q <= '0;
            typeB_q <= 1'b0;
            reqA_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            tgt_q <= tgt_d;
            subCnt_q <= subCnt_d;
            startEdge_q <= startEdge_d;
            sub_q <= sub_d;
            act_q <= act_d;
            quiet_q <= quiet_d;
            typeB_q <= typeB_d;
            reqA_q <= reqA_d;
        end
    end

    // UID storage and check byte; bytes are b8..b1 MSB first.
    logic [7:0] rd;
    logic [1:0] bIdx_q, bIdx_d, rdIdx_q;
    logic [7:0] acc_q, acc_d, chk_q, chk_d;
    tapt_uid_mem #(.DEPTH(16)) uidMem (
        .clk(clk),
        .we(uidWe),
        .waddr(uidWaddr),
        .wdata(uidWdata),
        .raddr({level, bIdx_q}),
        .rdata(rd)
    );
    always_comb begin
        bIdx_d = bIdx_q + 1'b1;
        acc_d = (rdIdx_q == 2'h0) ? rd : (acc_q ^ rd); // RULE6 RULE7 RULE9
        chk_d = (rdIdx_q == 2'h3) ? acc_d : chk_q;
        if (level == 2'h0 || level > `TAPT_MAX_LEVEL) begin // RULE8
            chk_d = 8'h00;
        end
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            bIdx_q <= 2'h0;
            rdIdx_q <= 2'h0;
            acc_q <= 8'h00;
            chk_q <= 8'h00;
        end else begin
            bIdx_q <= bIdx_d;
            rdIdx_q <= bIdx_q;
            acc_q <= acc_d;
            chk_q <= chk_d;
        end
    end
    // The cascade tag sits in byte 0 of its level and is folded into the check byte like any UID byte.

    assign startEdge = startEdge_q;
    assign subcarrier = sub_q;
    assign respActive = act_q;
    assign reqAReady = reqA_q;
    assign checkByte = chk_q;

    a_start_after_wait: assert property (@(posedge clk) disable iff (!nrst) // RULE18
        startEdge_q |-> $past(state_q) == TAPT_WAIT) else $error("start edge without wait");
    a_fixed_delay: assert property (@(posedge clk) disable iff (!nrst) // RULE12
        state_q == TAPT_WAIT && $past(state_q) == TAPT_IDLE && $past(cmdType) == TAPT_CMD_ANTICOLL
        |-> tgt_q == (N_WIDTH+8)'(`TAPT_N_FIXED * `TAPT_ETU_CYCLES + `TAPT_OFS_ZERO)
        || tgt_q == (N_WIDTH+8)'(`TAPT_N_FIXED * `TAPT_ETU_CYCLES + `TAPT_OFS_ONE)) else $error("bad fixed delay");
    a_grid_align: assert property (@(posedge clk) disable iff (!nrst) // RULE15
        state_q == TAPT_WAIT |-> tgt_q[6:0] == 7'(`TAPT_OFS_ONE) || tgt_q[6:0] == 7'(`TAPT_OFS_ZERO))
        else $error("off grid");
    a_silent_err: assert property (@(posedge clk) disable iff (!nrst) // RULE17
        state_q == TAPT_IDLE && cmdDone && !cmdOk |=> state_q == TAPT_IDLE) else $error("answered bad frame");
    a_sub_idle: assert property (@(posedge clk) disable iff (!nrst) // RULE5
        state_q == TAPT_IDLE |-> !sub_q) else $error("subcarrier while idle");
    a_n_min: assert property (@(posedge clk) disable iff (!nrst) // RULE13
        state_q == TAPT_WAIT |-> tgt_q >= (N_WIDTH+8)'(`TAPT_N_FIXED * `TAPT_ETU_CYCLES + `TAPT_OFS_ZERO))
        else $error("n below nine");
    a_typeb_block: assert property (@(posedge clk) disable iff (!nrst) // RULE2
        typeB_q |=> !reqA_q) else $error("request taken too soon");
    a_quiet_release: assert property (@(posedge clk) disable iff (!nrst) // RULE2 RULE3
        typeB_q && quiet_q == QW'(QUIET_CYCLES) && !pauS2_q && !cmdDone |=> !typeB_q)
        else $error("quiet field not released");
    a_level_range: assert property (@(posedge clk) disable iff (!nrst) // RULE8
        level == 2'h0 && rdIdx_q == 2'h3 |=> chk_q == 8'h00) else $error("bad level check");
endmodule // tapt_frame_timer
`default_nettype wire

// >>> tb/tapt_reader_model.sv
`timescale 1ns/100ps
`default_nettype none
module tapt_reader_model (
    input wire logic pauseReq, // Rise asks for a pause.
    input wire logic cardActive, // Card answer under way.
    output logic carrier, // Field carrier.
    output logic pauseIn, // Field pause.
    output int fdtCount, // Carrier rises since pause end.
    output int quiet // Carrier rises since the card went silent.
);
    initial begin
        carrier = 1'b0;
        forever #24 carrier = ~carrier;
    end
    initial begin
        fdtCount = 0;
        quiet = 1172;
        forever begin
            @(posedge carrier);
            fdtCount <= pauseIn ? 0 : fdtCount + 1;
            quiet <= cardActive ? 0 : quiet + 1;
        end
    end
    // A pause waits out the card's answer plus the minimum turnaround.
    initial begin
        pauseIn = 1'b0;
        forever begin
            @(posedge pauseReq);
            wait (quiet >= 1172 && cardActive === 1'b0);
            @(posedge carrier);
            pauseIn <= 1'b1;
            repeat (4) @(posedge carrier);
            pauseIn <= 1'b0;
        end
    end
endmodule // tapt_reader_model
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "tapt_params.svh"
module tb import tapt_pkg::*; ;
    logic clk, nrst, carrier, pauseIn, pauseReq, cmdDone, cmdOk, lastBit, uidWe;
    logic startEdge, subcarrier, respActive, reqAReady;
    tapt_cmd_t cmdType;
    logic [7:0] nReq, uidWdata, checkByte;
    logic [3:0] uidWaddr;
    logic [1:0] level;
    int fdtCount, quiet, readyCnt = 0, miscompares = 0, compares = 0, cyc = 0;
    tapt_frame_timer #(.QUIET_CYCLES(200), .N_WIDTH(8)) dut (.clk(clk), .nrst(nrst), .carrier(carrier),
        .pauseIn(pauseIn), .cmdDone(cmdDone), .cmdOk(cmdOk), .cmdType(cmdType), .lastBit(lastBit),
        .nReq(nReq), .uidWe(uidWe), .uidWaddr(uidWaddr), .uidWdata(uidWdata), .level(level),
        .startEdge(startEdge), .subcarrier(subcarrier), .respActive(respActive),
        .reqAReady(reqAReady), .checkByte(checkByte));
    tapt_reader_model rdr (.pauseReq(pauseReq), .cardActive(respActive), .carrier(carrier),
        .pauseIn(pauseIn), .fdtCount(fdtCount), .quiet(quiet));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (reqAReady === 1'b1) readyCnt <= readyCnt + 1;
        // The scenarios need about 98,600 cycles, mostly frame delays and reader turnaround.
        if (cyc == 100000) begin
            miscompares++;
            report_and_stop();
        end
    end
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t value %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic cmp_flag(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    function automatic int exp_fdt(input int n, input logic lb);
        return n * `TAPT_ETU_CYCLES + (lb ? `TAPT_OFS_ONE : `TAPT_OFS_ZERO);
    endfunction
    task automatic send_cmd(input tapt_cmd_t t, input logic ok, input logic lb, input logic [7:0] n,
                            input logic p);
        @(negedge clk);
        cmdType = t;
        cmdOk = ok;
        lastBit = lb;
        nReq = n;
        cmdDone = 1'b1;
        @(negedge clk);
        cmdDone = 1'b0;
        pauseReq = p;
        @(negedge clk);
        pauseReq = 1'b0;
    endtask
    task automatic wait_start(input int lim, output logic seen);
        seen = 1'b0;
        repeat (lim) begin
            @(posedge clk);
            #1;
            if (startEdge === 1'b1) begin
                seen = 1'b1;
                break;
            end
        end
    endtask
    // Slot length is judged in carrier edges, not system cycles; subcarrier periods by counting its falling edges in the slot.
    task automatic fdt_case(input tapt_cmd_t t, input logic lb, input logic [7:0] n, input int exp);
        logic seen, prev;
        int t0, falls;
        // The timer counts from the command strobe until a pause end restarts it, so the pause must follow at once.
        wait (quiet >= 1172);
        send_cmd(t, 1'b1, lb, n, 1'b1);
        wait_start(26000, seen);
        cmp_flag(seen, 1'b1);
        cmp_val(fdtCount, exp);
        t0 = fdtCount;
        falls = 0;
        prev = subcarrier;
        repeat (2000) begin
            @(posedge clk);
            #1;
            if (prev === 1'b1 && subcarrier === 1'b0) falls++;
            prev = subcarrier;
            if (respActive !== 1'b1) break;
        end
        cmp_val(fdtCount - t0, `TAPT_ETU_CYCLES);
        cmp_val(falls, `TAPT_ETU_CYCLES / `TAPT_SUB_DIV);
        $display("test fdt %0d done", exp);
    endtask
    task automatic test_uid;
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            uidWe = 1'b1;
            uidWaddr = (i < 4) ? 4'(4 + i) : 4'(8 + i);
            uidWdata = (i < 4) ? (8'h88 >> i) : (8'h0F << (i - 4));
        end
        @(negedge clk);
        uidWe = 1'b0;
        level = 2'h1;
        repeat (3) @(negedge clk);
        cmp_val(checkByte, 8'hFF);
        level = 2'h3;
        repeat (9) @(negedge clk);
        cmp_val(checkByte, 8'h55);
        level = 2'h0;
        repeat (3) @(negedge clk);
        cmp_val(checkByte, 8'h00);
        $display("test uid done");
    endtask
    task automatic test_error;
        logic seen;
        send_cmd(TAPT_CMD_ANTICOLL, 1'b0, 1'b0, 8'h09, 1'b1);
        wait_start(11800, seen);
        cmp_flag(seen, 1'b0);
        $display("test error done");
    endtask
    task automatic test_typeb;
        int r0;
        send_cmd(TAPT_CMD_TYPEB, 1'b1, 1'b0, 8'h09, 1'b1);
        repeat (60) @(negedge clk);
        r0 = readyCnt;
        send_cmd(TAPT_CMD_ANTICOLL, 1'b1, 1'b1, 8'h09, 1'b0);
        repeat (4) @(negedge clk);
        cmp_val(readyCnt - r0, 0);
        repeat (300) @(negedge clk);
        fdt_case(TAPT_CMD_ANTICOLL, 1'b1, 8'h09, exp_fdt(`TAPT_N_FIXED, 1'b1));
        cmp_val(readyCnt - r0, 1);
        $display("test quiet done");
    endtask
    task automatic report_and_stop;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        nrst = 1'b0;
        pauseReq = 1'b0;
        cmdDone = 1'b0;
        cmdOk = 1'b0;
        cmdType = TAPT_CMD_ANTICOLL;
        lastBit = 1'b0;
        nReq = 8'h09;
        uidWe = 1'b0;
        uidWaddr = 4'h0;
        uidWdata = 8'h00;
        level = 2'h1;
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        cmp_flag(startEdge | respActive | reqAReady, 1'b0);
        test_uid();
        test_error();
        test_typeb();
        fdt_case(TAPT_CMD_ANTICOLL, 1'b0, 8'h09, exp_fdt(`TAPT_N_FIXED, 1'b0));
        fdt_case(TAPT_CMD_OTHER, 1'b1, 8'h0A, exp_fdt(10, 1'b1));
        fdt_case(TAPT_CMD_OTHER, 1'b0, 8'h04, exp_fdt(9, 1'b0));
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
